//--- hdl/ssf_pkg.sv
/*
 * constants, field layout and carrier types of the serial port status block.
 * assumes a 32-bit ahb-lite register bus and a 250 MHz ref_clk.
 */
package ssf_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [31:0] SSF_ADDR_STATUS = 32'hffff0a00;
    localparam logic [31:0] SSF_ADDR_RXB = 32'hffff0a04;
    localparam logic [31:0] SSF_ADDR_TXB = 32'hffff0a08;
    localparam logic [31:0] SSF_ADDR_DIV = 32'hffff0a0c;

    // ************************************************************
    // status fields
    // ************************************************************
    localparam int SSF_BIT_REX = 11;
    localparam int SSF_RXL_HI = 10;
    localparam int SSF_RXL_LO = 8;
    localparam int SSF_BIT_OVF = 7;
    localparam int SSF_BIT_RXI = 6;
    localparam int SSF_BIT_TXI = 5;
    localparam int SSF_BIT_UFL = 4;
    localparam int SSF_TXL_HI = 3;
    localparam int SSF_TXL_LO = 1;
    localparam int SSF_BIT_SUM = 0;
    localparam int SSF_DIV_HI = 5;

    // ************************************************************
    // sizes and reset values
    // ************************************************************
    localparam logic [2:0] SSF_DEPTH = 3'h4;
    localparam logic [2:0] SSF_LAST_BIT = 3'h7;
    localparam logic [5:0] SSF_DIV_RST = 6'h1b;
    localparam logic [7:0] SSF_IDLE_BYTE = 8'h00;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic [1:0] thr_mode;  // interrupt_threshold_mode
        logic xfer_mode;       // transfer_initiate_mode
        logic tx_flush;        // transmit_flush_control
        logic rx_flush;        // receive_flush_control
        logic master;
        logic cont;
        logic loopback;
    } ssf_ctrl_t;

    typedef struct packed {
        logic sclk_i;
        logic ss_n_i;
        logic mosi_i;
        logic miso_i;
    } ssf_pin_in_t;

    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic ss_n_o;
        logic ss_n_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } ssf_pin_out_t;

    typedef struct packed {
        logic ovf;
        logic rxi;
        logic txi;
        logic ufl;
        logic sum;
    } ssf_flags_t;

    typedef enum logic [2:0] {
        SSF_ST_IDLE = 3'b001,
        SSF_ST_SHIFT = 3'b010,
        SSF_ST_GAP = 3'b100
    } ssf_state_t;

endpackage

//--- hdl/ssf_fifo.sv
/*
 * four-byte queue built as a shift register; head and level are flops.
 * assumes push is dropped by the caller's view when full; flush wins.
 */
`timescale 1ns/1ps
module ssf_fifo (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic push,
    input wire logic [7:0] push_data,
    input wire logic pop,
    input wire logic flush,
    // state
    output logic [7:0] head,
    output logic [2:0] level
);
    import ssf_pkg::*;

    logic [7:0] slot_r [4];
    logic [7:0] slot_nxt [4];
    logic [2:0] level_r;
    logic [2:0] level_nxt;

    always_comb begin
        slot_nxt = slot_r;
        level_nxt = level_r;
        if (flush) begin
            level_nxt = 3'h0;
        end else begin
            if (pop && level_nxt != 3'h0) begin
                for (int i = 0; i < 3; i++) begin
                    slot_nxt[i] = slot_r[i+1];
                end
                level_nxt = level_nxt - 3'h1;
            end
            // a push into a full queue is lost unless a pop comes in the same cycle; the receive side flags ovf either way
            if (push && level_nxt != SSF_DEPTH) begin
                slot_nxt[level_nxt[1:0]] = push_data;
                level_nxt = level_nxt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                slot_r[i] <= 8'h00;
            end
            level_r <= 3'h0;
        end else begin
            slot_r <= slot_nxt;
            level_r <= level_nxt;
        end
    end

    assign head = slot_r[0];
    assign level = level_r;
endmodule

//--- hdl/ssf_port.sv
/*
 * serial port status, data and divider registers with the byte shifter.
 * assumes one ahb-lite master and pins synchronous to ref_clk.
 */
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ssf_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // control bits held outside
    input wire ssf_pkg::ssf_ctrl_t ctrl,
    // serial pins
    input wire ssf_pkg::ssf_pin_in_t pin_in,
    output ssf_pkg::ssf_pin_out_t pin_out
);
    import ssf_pkg::*;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic acc;
    logic nrst_q;
    logic st_rd;
    logic rxb_rd;
    logic wr_tx_r;
    logic wr_tx_nxt;
    logic wr_div_r;
    logic wr_div_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic [31:0] status_w;
    logic [5:0] div_r;
    logic [5:0] div_nxt;

    assign acc = hsel && htrans[1] && hready;
    assign st_rd = acc && !hwrite && haddr == SSF_ADDR_STATUS;
    assign rxb_rd = acc && !hwrite && haddr == SSF_ADDR_RXB;

    // ************************************************************
    // queues and flags
    // ************************************************************
    logic [7:0] rx_head;
    logic [2:0] rx_lvl;
    logic [7:0] tx_head;
    logic [2:0] tx_lvl;
    logic rx_push;
    logic [7:0] rx_byte;
    logic tx_pop;
    logic tx_push;
    logic byte_done;
    logic start;
    logic [2:0] thr;
    ssf_flags_t flags_r;
    ssf_flags_t flags_nxt;
    logic rex_r;
    logic rex_nxt;
    logic [1:0] tx_cnt_r;
    logic [1:0] tx_cnt_nxt;
    logic ev_ovf;
    logic ev_rxi;
    logic ev_txi;
    logic ev_ufl;

    assign thr = {1'b0, ctrl.thr_mode} + 3'h1;
    // writes vanish while flushing or when the queue is full
    assign tx_push = wr_tx_r && !ctrl.tx_flush && tx_lvl != SSF_DEPTH;

    ssf_fifo u_rx (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .push(rx_push),
        .push_data(rx_byte),
        .pop(rxb_rd),
        .flush(ctrl.rx_flush),
        .head(rx_head),
        .level(rx_lvl)
    );

    ssf_fifo u_tx (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .push(tx_push),
        .push_data(hwdata[7:0]),
        .pop(tx_pop),
        .flush(ctrl.tx_flush),
        .head(tx_head),
        .level(tx_lvl)
    );

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[SSF_BIT_REX] = rex_r;
        status_w[SSF_RXL_HI:SSF_RXL_LO] = rx_lvl;
        status_w[SSF_BIT_OVF] = flags_r.ovf;
        status_w[SSF_BIT_RXI] = flags_r.rxi;
        status_w[SSF_BIT_TXI] = flags_r.txi;
        status_w[SSF_BIT_UFL] = flags_r.ufl;
        status_w[SSF_TXL_HI:SSF_TXL_LO] = tx_lvl;
        status_w[SSF_BIT_SUM] = flags_r.sum;
        hrdata_nxt = 32'h0000_0000;
        if (st_rd) begin
            hrdata_nxt = status_w;
        end else if (rxb_rd && rx_lvl != 3'h0) begin
            hrdata_nxt = {24'h00_0000, rx_head};
        end
        wr_tx_nxt = acc && hwrite && haddr == SSF_ADDR_TXB;
        wr_div_nxt = acc && hwrite && haddr == SSF_ADDR_DIV;
        div_nxt = wr_div_r ? hwdata[SSF_DIV_HI:0] : div_r;
    end

    always_comb begin
        // receive flush keeps bytes, ovf, rxi and sum out; txi and ufl still set their flags
        ev_ovf = byte_done && !ctrl.rx_flush && rx_lvl == SSF_DEPTH;
        ev_rxi = rx_push && !ctrl.xfer_mode && rx_lvl + 3'h1 >= thr;
        ev_txi = byte_done && ctrl.xfer_mode && tx_cnt_r == thr[1:0] - 2'h1;
        ev_ufl = start && tx_lvl == 3'h0;
        tx_cnt_nxt = tx_cnt_r;
        if (byte_done && ctrl.xfer_mode) begin
            tx_cnt_nxt = ev_txi ? 2'h0 : tx_cnt_r + 2'h1;
        end
        // a set in the clearing cycle wins over the read clear
        flags_nxt.ovf = ev_ovf || (flags_r.ovf && !st_rd);
        flags_nxt.rxi = ev_rxi || (flags_r.rxi && !st_rd);
        flags_nxt.txi = ev_txi || (flags_r.txi && !st_rd);
        flags_nxt.ufl = ev_ufl || (flags_r.ufl && !st_rd);
        flags_nxt.sum = (!ctrl.rx_flush && ((ev_ovf) || ev_rxi || ev_txi
            || (ev_ufl && !ctrl.tx_flush))) || (flags_r.sum && !st_rd);
        rex_nxt = rx_lvl > thr;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_r <= 32'h0000_0000;
            wr_tx_r <= 1'b0;
            wr_div_r <= 1'b0;
            div_r <= SSF_DIV_RST;
            flags_r <= '0;
            rex_r <= 1'b0;
            tx_cnt_r <= 2'h0;
        end else begin
            hrdata_r <= hrdata_nxt;
            wr_tx_r <= wr_tx_nxt;
            wr_div_r <= wr_div_nxt;
            div_r <= div_nxt;
            flags_r <= flags_nxt;
            rex_r <= rex_nxt;
            tx_cnt_r <= tx_cnt_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = nrst_q;
    assign hresp = 1'b0;

    // ************************************************************
    // byte shifter
    // ************************************************************
    ssf_state_t st_r;
    ssf_state_t st_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [2:0] bit_r;
    logic [2:0] bit_nxt;
    logic smp_r;
    logic smp_nxt;
    logic go_r;
    logic go_nxt;
    logic sclk_q;
    logic tick;
    logic rise;
    logic fall;
    logic rx_in;
    logic more;
    logic [7:0] load_byte;
    ssf_pin_out_t po_r;
    ssf_pin_out_t po_nxt;

    assign tick = cnt_r == div_r;
    assign rise = ctrl.master ? tick && !po_r.sclk_o : pin_in.sclk_i && !sclk_q;
    assign fall = ctrl.master ? tick && po_r.sclk_o : !pin_in.sclk_i && sclk_q;
    assign rx_in = !ctrl.master ? pin_in.mosi_i
        : (ctrl.loopback ? po_r.mosi_o : pin_in.miso_i);
    assign load_byte = tx_lvl != 3'h0 ? tx_head : SSF_IDLE_BYTE;
    // the current byte was popped at its start, so any level left is more data
    assign more = ctrl.master ? ctrl.cont && tx_lvl != 3'h0 : !pin_in.ss_n_i;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = (st_r == SSF_ST_IDLE || tick) ? 6'h00 : cnt_r + 6'h01;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        smp_nxt = smp_r;
        po_nxt = po_r;
        start = 1'b0;
        tx_pop = 1'b0;
        byte_done = 1'b0;
        rx_push = 1'b0;
        rx_byte = {sh_r[6:0], smp_r};
        // without transfer mode a receive read asks for the next byte
        go_nxt = go_r || (rxb_rd && !ctrl.xfer_mode);
        po_nxt.sclk_oe = ctrl.master;
        po_nxt.ss_n_oe = ctrl.master;
        po_nxt.mosi_oe = ctrl.master;
        po_nxt.miso_oe = !ctrl.master && !pin_in.ss_n_i;
        case (st_r)
            SSF_ST_IDLE: begin
                po_nxt.sclk_o = 1'b0;
                po_nxt.ss_n_o = 1'b1;
                if (ctrl.master ? (ctrl.xfer_mode ? tx_lvl != 3'h0 : go_r)
                    : !pin_in.ss_n_i) begin
                    start = 1'b1;
                    go_nxt = 1'b0;
                    tx_pop = 1'b1;
                    sh_nxt = load_byte;
                    bit_nxt = 3'h0;
                    po_nxt.ss_n_o = !ctrl.master;
                    st_nxt = SSF_ST_SHIFT;
                end
            end
            SSF_ST_SHIFT: begin
                if (ctrl.master && tick) begin
                    po_nxt.sclk_o = !po_r.sclk_o;
                end
                if (rise) begin
                    smp_nxt = rx_in;
                end
                if (fall) begin
                    sh_nxt = {sh_r[6:0], smp_r};
                    bit_nxt = bit_r + 3'h1;
                    if (bit_r == SSF_LAST_BIT) begin
                        byte_done = 1'b1;
                        rx_push = !ctrl.rx_flush;
                        if (more) begin
                            start = 1'b1;
                            tx_pop = 1'b1;
                            sh_nxt = load_byte;
                        end else begin
                            po_nxt.ss_n_o = 1'b1;
                            st_nxt = ctrl.master ? SSF_ST_GAP : SSF_ST_IDLE;
                        end
                    end
                end
                if (!ctrl.master && pin_in.ss_n_i) begin
                    st_nxt = SSF_ST_IDLE;
                end
            end
            SSF_ST_GAP: begin
                // one idle serial clock between single transfers
                if (tick) begin
                    po_nxt.sclk_o = !po_r.sclk_o;
                    if (po_r.sclk_o) begin
                        st_nxt = SSF_ST_IDLE;
                    end
                end
            end
            default: begin
                st_nxt = SSF_ST_IDLE;
            end
        endcase
        po_nxt.mosi_o = sh_nxt[7];
        po_nxt.miso_o = sh_nxt[7];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nrst_q <= 1'b0;
            st_r <= SSF_ST_IDLE;
            cnt_r <= 6'h00;
            sh_r <= 8'h00;
            bit_r <= 3'h0;
            smp_r <= 1'b0;
            go_r <= 1'b0;
            sclk_q <= 1'b0;
            po_r <= '{ss_n_o: 1'b1, default: 1'b0};
        end else begin
            nrst_q <= 1'b1;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            smp_r <= smp_nxt;
            go_r <= go_nxt;
            sclk_q <= pin_in.sclk_i;
            po_r <= po_nxt;
        end
    end

    assign pin_out = po_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_ovf_set: assert property (ev_ovf |=> flags_r.ovf)
        else $error("overflow flag missed");
    a_sum_clear: assert property (st_rd && !flags_nxt.ovf && !ev_rxi && !ev_txi
        && !ev_ufl |=> !flags_r.sum)
        else $error("summary flag not cleared by read");
    a_rex_level: assert property (rx_lvl <= thr && $stable(thr) |=> !rex_r)
        else $error("excess flag set at or below threshold");
    a_level_bound: assert property (rx_lvl <= SSF_DEPTH && tx_lvl <= SSF_DEPTH)
        else $error("queue level above four");
    a_txflush_drop: assert property (ctrl.tx_flush |=> tx_lvl == 3'h0)
        else $error("transmit queue filled while flushing");
    a_rxflush_quiet: assert property (ctrl.rx_flush |=> !$rose(flags_r.sum))
        else $error("interrupt raised while receive flushing");
    a_ufl_set: assert property (start && tx_lvl == 3'h0 |=> flags_r.ufl)
        else $error("underflow flag missed");
    a_div_rate: assert property (st_r == SSF_ST_SHIFT && ctrl.master && $stable(div_r)
        && $changed(po_r.sclk_o) |-> $past(cnt_r) == div_r)
        else $error("serial clock half period wrong");
    a_rd_pop: assert property (rxb_rd && rx_lvl != 3'h0 && !rx_push && !ctrl.rx_flush
        |=> rx_lvl == $past(rx_lvl) - 3'h1)
        else $error("receive read did not pop");
    a_txi_mode: assert property (!ctrl.xfer_mode && !flags_r.txi |=> !flags_r.txi)
        else $error("transmit flag without transfer mode");

    c_byte_done: cover property (byte_done ##1 st_r == SSF_ST_GAP);
    c_overflow: cover property (ev_ovf);
    c_status_read: cover property (flags_r.sum ##1 st_rd);
    c_cont_byte: cover property (byte_done && start);
endmodule

//--- bench/ssf_slave_model.sv
/*
 * behavioural serial slave facing the port in master mode, clock mode 0.
 * assumes sclk idles low and select goes low around each byte.
 */
`timescale 1ns/1ps
module ssf_slave_model (
    // serial pins from the port
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    // reply base and capture
    input wire logic [7:0] base,
    output logic miso,
    output logic [7:0] cnt,
    output logic [7:0] got [0:15]
);
    logic [7:0] sh;
    logic [7:0] out;
    logic [7:0] nbytes = 8'h00;
    int nb = 0;

    // ************************************************************
    // shifter
    // ************************************************************
    assign cnt = nbytes;
    // sample on rise; the unit closes on its eighth rise, since select
    // may rise in the same step as the last fall
    always @(posedge sclk) begin
        if (!ss_n) begin
            sh = {sh[6:0], mosi};
            nb++;
            if (nb == 8) begin
                got[nbytes[3:0]] = sh;
                nbytes = nbytes + 8'h01;
                nb = 0;
            end
        end
    end
    // reply byte k is base plus k, msb first, shifted on fall
    // released line: inverse of last bit so no stale value passes
    always @(negedge ss_n or negedge sclk or posedge ss_n) begin
        out = base + nbytes;
        if (ss_n) begin
            miso = ~miso;
        end else begin
            miso = out[7 - nb];
        end
    end
endmodule

//--- bench/ssf_port_tb.sv
/*
 * self-checking bench for the serial port status block in master mode.
 * assumes the slave model on the pins and single word ahb-lite transfers.
 */
`timescale 1ns/1ps
module ssf_port_tb;
    import ssf_pkg::*;
    logic ref_clk;
    logic nrst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    ssf_ctrl_t ctrl;
    ssf_pin_in_t pin_in;
    ssf_pin_out_t pin_out;
    logic miso;
    logic [7:0] base;
    logic [7:0] cnt;
    logic [7:0] got [0:15];
    logic [7:0] d [0:4];
    logic [31:0] v;
    logic [7:0] hcnt = 8'h00;
    logic [7:0] half = 8'h00;
    int frames;
    int f0;
    integer seed;
    int fails;
    int checked;

    // ************************************************************
    // design, partner, clock
    // ************************************************************
    assign pin_in = '{sclk_i: 1'b0, ss_n_i: 1'b1, mosi_i: 1'b0, miso_i: miso};
    ssf_port u_dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ctrl(ctrl), .pin_in(pin_in),
        .pin_out(pin_out));
    ssf_slave_model u_slave (.sclk(pin_out.sclk_o), .ss_n(pin_out.ss_n_o),
        .mosi(pin_out.mosi_o), .base(base), .miso(miso), .cnt(cnt), .got(got));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // high time of sclk in ref_clk cycles
    always @(posedge ref_clk) begin
        if (pin_out.sclk_o === 1'b1) begin
            hcnt <= hcnt + 8'h01;
        end else if (hcnt != 8'h00) begin
            half <= hcnt;
            hcnt <= 8'h00;
        end
    end
    // select releases seen on the pin
    always @(posedge pin_out.ss_n_o) begin
        frames <= frames + 1;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // hold each phase until hready is sampled high
    // no wait count assumed: only the watchdog ends a stuck bus
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            @(posedge ref_clk);
        end
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] x;
        ahb(1'b1, a, wd, x);
    endtask
    task automatic rd(input logic [31:0] a);
        ahb(1'b0, a, 32'h0, v);
    endtask
    // bounded wait for the partner to hold t bytes, then let the port settle
    task automatic wait_bytes(input logic [7:0] t);
        int n;
        n = 0;
        while (cnt !== t && n < 4000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 4000) begin
            fails++;
            print_verdict();
        end
        repeat (80) @(posedge ref_clk);
    endtask
    function automatic logic [31:0] stv(input logic rex, input logic [2:0] rxl,
        input logic [3:0] fl, input logic [2:0] txl, input logic sum);
        stv = {20'h00000, rex, rxl, fl, txl, sum};
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        print_verdict();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        seed = 32'h8624;
        fails = 0;
        checked = 0;
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ctrl = '0;
        ctrl.master = 1'b1;
        ctrl.xfer_mode = 1'b1;
        base = 8'h3c;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd(SSF_ADDR_STATUS);
        check("status reset", v, 32'h0);
        rd(SSF_ADDR_RXB);
        check("rx reset", v, 32'h0);
        wr(SSF_ADDR_STATUS, 32'hffffffff);
        wr(32'hffff0a14, 32'hffffffff);
        rd(SSF_ADDR_STATUS);
        check("status ro", v, 32'h0);
        rd(SSF_ADDR_TXB);
        check("tx wo", v, 32'h0);
        rd(32'hffff0a14);
        check("unmapped", v, 32'h0);
        $display("test reset done");
        // queue fills to four, a fifth write is refused
        ctrl.xfer_mode <= 1'b0;
        ctrl.thr_mode <= 2'h3;
        for (int i = 0; i < 5; i++) begin
            wr(SSF_ADDR_TXB, {24'h0, 8'($random(seed))});
        end
        rd(SSF_ADDR_STATUS);
        check("tx level", v, stv(0, 0, 0, 4, 0));
        ctrl.tx_flush <= 1'b1;
        repeat (2) @(posedge ref_clk);
        wr(SSF_ADDR_TXB, 32'h5a);
        rd(SSF_ADDR_STATUS);
        check("flushed", v, 32'h0);
        $display("test levels done");
        // rx read starts a transfer on an empty queue, flush keeps the event out of the summary
        rd(SSF_ADDR_RXB);
        wait_bytes(8'h01);
        check("idle byte", got[0], SSF_IDLE_BYTE);
        check("div reset", half, 32'h1c);
        rd(SSF_ADDR_STATUS);
        check("ufl flushed", v, stv(0, 1, 4'b0001, 0, 0));
        ctrl.tx_flush <= 1'b0;
        ctrl.thr_mode <= 2'h0;
        wr(SSF_ADDR_DIV, 32'h02);
        rd(SSF_ADDR_RXB);
        check("rx byte 0", v, base);
        wait_bytes(8'h02);
        check("div 2", half, 32'h3);
        rd(SSF_ADDR_STATUS);
        check("ufl rxi", v, stv(0, 1, 4'b0101, 0, 1));
        $display("test underflow done");
        // three bytes sent with threshold two
        ctrl.xfer_mode <= 1'b1;
        ctrl.thr_mode <= 2'h1;
        rd(SSF_ADDR_RXB);
        rd(SSF_ADDR_STATUS);
        for (int i = 0; i < 5; i++) begin
            d[i] = 8'($random(seed));
        end
        for (int i = 0; i < 3; i++) begin
            wr(SSF_ADDR_TXB, {24'h0, d[i]});
        end
        wait_bytes(8'h05);
        for (int i = 0; i < 3; i++) begin
            check("mosi byte", got[i + 2], d[i]);
        end
        rd(SSF_ADDR_STATUS);
        check("txi rex", v, stv(1, 3, 4'b0010, 0, 1));
        rd(SSF_ADDR_STATUS);
        check("cleared", v, stv(1, 3, 0, 0, 0));
        $display("test transmit done");
        // two more bytes: the fifth received byte overflows and is dropped
        wr(SSF_ADDR_TXB, {24'h0, d[3]});
        wr(SSF_ADDR_TXB, {24'h0, d[4]});
        wait_bytes(8'h07);
        rd(SSF_ADDR_STATUS);
        check("overflow", v & 32'hf81, stv(1, 4, 4'b1000, 0, 1));
        for (int k = 0; k < 4; k++) begin
            rd(SSF_ADDR_RXB);
            check("rx pop", v, 32'(base + 8'(k + 2)));
            rd(SSF_ADDR_STATUS);
            check("rx level", v & 32'hf00, {20'h0, (3 - k) > 2, 3'(3 - k), 8'h0});
        end
        $display("test overflow done");
        // receive flush drops the byte and raises no ovf or sum; rxi and txi are masked out of the check
        ctrl.rx_flush <= 1'b1;
        ctrl.thr_mode <= 2'h0;
        wr(SSF_ADDR_TXB, 32'h96);
        wait_bytes(8'h08);
        rd(SSF_ADDR_STATUS);
        check("rx flushed", v & 32'hf81, 32'h0);
        $display("test flush done");
        // loopback, continuous: two bytes under one select
        ctrl.rx_flush <= 1'b0;
        ctrl.loopback <= 1'b1;
        ctrl.cont <= 1'b1;
        f0 = frames;
        wr(SSF_ADDR_TXB, {24'h0, d[0]});
        wr(SSF_ADDR_TXB, {24'h0, d[1]});
        wait_bytes(8'h0a);
        check("frames", frames - f0, 32'h1);
        check("mosi cont", got[9], d[1]);
        for (int i = 0; i < 2; i++) begin
            rd(SSF_ADDR_RXB);
            check("loopback", v, {24'h0, d[i]});
        end
        $display("test loopback done");
        print_verdict();
    end
endmodule
